// ### hdl/tios_defines.svh
// Register map, field positions, reset values and timing counts for the interrupt status block
`ifndef TIOS_DEFINES_SVH
`define TIOS_DEFINES_SVH

`define TIOS_IDX_WRAP_IRQ   8'h1D
`define TIOS_IDX_EVENT_IRQ  8'h1E
`define TIOS_IDX_WRAP_LATCH 8'h1F
`define TIOS_IDX_WRAP_MASK  8'h20
`define TIOS_IDX_EVENT_MASK 8'h21
`define TIOS_IDX_CONTROL    8'h22
`define TIOS_ADDR_W         8

`define TIOS_RST_STATUS     8'h00
`define TIOS_RST_MASK       8'h00
`define TIOS_RST_CONTROL    8'h00

`define TIOS_W3_FDL_CTRL    6
`define TIOS_W3_SIG_CTRL    5
`define TIOS_W3_LOOP        4
`define TIOS_W3_ONE_SEC     3
`define TIOS_W3_FIVE_SEC    2
`define TIOS_W3_BIT_MSG     1
`define TIOS_W3_SIG_CHANGE  0
`define TIOS_CTL_DEBOUNCE   0
`define TIOS_W3_USED_MASK   8'h7F

`define TIOS_WRAP_FROM      8'hFF
`define TIOS_WRAP_TO        8'h00

`define TIOS_CLK_HZ         40000000
`define TIOS_LOOP_TIME_MS   48
`define TIOS_LOOP_CYCLES    ((`TIOS_LOOP_TIME_MS * `TIOS_CLK_HZ) / 1000)

`define TIOS_BOM_LEN        16
`define TIOS_BOM_HIST       10
`define TIOS_BOM_NEED       8
`define TIOS_BOM_FLAG       8'hFF

`endif

// ### hdl/tios_pkg.sv
// Types shared by the interrupt status block
package tios_pkg;
  typedef logic [7:0] tios_byte_t;
  typedef enum logic [2:0] {
    TIOS_SEL_NONE,
    TIOS_SEL_WRAP_IRQ,
    TIOS_SEL_EVENT_IRQ,
    TIOS_SEL_WRAP_LATCH,
    TIOS_SEL_WRAP_MASK,
    TIOS_SEL_EVENT_MASK,
    TIOS_SEL_CONTROL
  } tios_sel_e;
endpackage : tios_pkg

// ### hdl/tios_loop_detect.sv
// Loop-up and loop-down code persistence detector
`timescale 1ns/10ps
`include "tios_defines.svh"
module tios_loop_detect
  import tios_pkg::*;
#(
  parameter int LOOP_CYCLES = `TIOS_LOOP_CYCLES
)(
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic rx_bit,
  input  wire logic rx_bit_valid,
  output logic      loop_ev
);
  logic [4:0] hist_q;
  logic [1:0] match;
  logic [1:0] ok_q;
  logic [1:0] hit;

  // Period five with a single one, period three with a single one
  assign match[0] = (rx_bit == hist_q[4]) && ($countones({hist_q[3:0], rx_bit}) == 1);
  assign match[1] = (rx_bit == hist_q[2]) && ($countones({hist_q[1:0], rx_bit}) == 1);

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      hist_q <= 5'h00;
    else if (rx_bit_valid)
      hist_q <= {hist_q[3:0], rx_bit};

  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : g_pat
      logic [31:0] tmr_q;
      always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
          ok_q[g] <= 1'b0;
        else if (rx_bit_valid)
          ok_q[g] <= match[g];
      // Timer saturates so one persistent code reports once
      always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
          tmr_q <= 32'h0000_0000;
        else if (!ok_q[g] || (rx_bit_valid && !match[g]))
          tmr_q <= 32'h0000_0000;
        else if (tmr_q < 32'(LOOP_CYCLES))
          tmr_q <= tmr_q + 32'h0000_0001;
      assign hit[g] = ok_q[g] && !(rx_bit_valid && !match[g]) && (tmr_q == 32'(LOOP_CYCLES - 1));
    end
  endgenerate

  assign loop_ev = |hit;
endmodule : tios_loop_detect

// ### hdl/tios_bom_detect.sv
// Bit-oriented message detector with 8-of-10 acceptance
`timescale 1ns/10ps
`include "tios_defines.svh"
module tios_bom_detect
  import tios_pkg::*;
(
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic fdl_bit,
  input  wire logic fdl_valid,
  output logic      bom_ev
);
  logic [15:0] sr_q;
  logic [15:0] sr_d;
  logic [3:0]  pos_q;
  logic [6:0]  hist_q [`TIOS_BOM_HIST];
  logic [6:0]  acc_q;
  logic [`TIOS_BOM_HIST-1:0] same;
  logic        hit;
  logic        push;
  logic [6:0]  entry;

  assign sr_d  = {sr_q[14:0], fdl_bit};
  assign hit   = (sr_d[15:8] == `TIOS_BOM_FLAG) && !sr_d[7] && !sr_d[0];
  // A position with no valid message is pushed as invalid
  assign push  = fdl_valid && (hit || (pos_q == 4'hF));
  assign entry = hit ? {1'b1, sr_d[6:1]} : 7'h00;

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      sr_q  <= 16'h0000;
      pos_q <= 4'h0;
    end
    else if (fdl_valid)
    begin
      sr_q  <= sr_d;
      pos_q <= push ? 4'h0 : pos_q + 4'h1;
    end

  genvar g;
  generate
    for (g = 0; g < `TIOS_BOM_HIST; g++)
    begin : g_hist
      always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
          hist_q[g] <= 7'h00;
        else if (push)
          hist_q[g] <= (g == 0) ? entry : hist_q[(g == 0) ? 0 : g - 1];
      assign same[g] = hist_q[0][6] && (hist_q[g] == hist_q[0]);
    end
  endgenerate

  assign bom_ev = ($countones(same) >= `TIOS_BOM_NEED) && (hist_q[0] != acc_q);

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      acc_q <= 7'h00;
    else if (bom_ev)
      acc_q <= hist_q[0];

  property p_bom_needs_eight;
    @(posedge pclk) disable iff (!presetn)
      bom_ev |-> hist_q[0][6] && ($countones(same) > 7);
  endproperty
  a_bom_needs_eight: assert property (p_bom_needs_eight) else $error("message accepted without 8 of 10");
endmodule : tios_bom_detect

// ### hdl/tios_status.sv
// Read-clearable interrupt and overflow latch status registers on APB
// Behaviour
// - Frame bit error counter wrap FF to 00 sets its interrupt bit if unmasked.
// - CRC error counter wrap FF to 00 sets its interrupt bit if unmasked.
// - Out-of-frame counter wrap FF to 00 sets its interrupt bit if unmasked.
// - Alignment change counter wrap FF to 00 sets its interrupt bit if unmasked.
// - Line violation counter wrap FF to 00 sets its interrupt bit if unmasked.
// - Test pattern error counter wrap sets its interrupt bit if unmasked.
// - Test pattern multiframe counter wrap sets its bit; mask one means enabled.
// - Multiframe sync loss counter wrap sets its interrupt bit if unmasked.
// - Masked events never set an interrupt status bit.
// - Reading an interrupt word clears its set bits.
// - Unmasked facility link controller event sets its interrupt bit.
// - Unmasked signaling link controller event sets its interrupt bit.
// - Loop-up or loop-down code held 48 ms sets loop code interrupt.
// - Rising one-second flag sets the one-second interrupt if unmasked.
// - Rising five-second flag sets the five-second interrupt if unmasked.
// - New differing bit-oriented message sets the message interrupt.
// - A message is accepted only after 8 of last 10 positions.
// - Signaling pattern change sets interrupt, debounced value when enabled.
// - Eight overflow latches set on counter wrap, cleared after read.
`timescale 1ns/10ps
`include "tios_defines.svh"
module tios_status
  import tios_pkg::*;
#(
  parameter int LOOP_CYCLES = `TIOS_LOOP_CYCLES
)(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [7:0]  frame_bit_err_count,
  input  wire logic [7:0]  crc_err_count,
  input  wire logic [7:0]  out_of_frame_count,
  input  wire logic [7:0]  align_change_count,
  input  wire logic [7:0]  line_violation_count,
  input  wire logic [7:0]  test_pattern_err_count,
  input  wire logic [7:0]  test_pattern_mf_count,
  input  wire logic [7:0]  multiframe_sync_loss_count,
  input  wire logic        facility_link_ctrl_event,
  input  wire logic        signaling_link_ctrl_event,
  input  wire logic        rx_line_bit,
  input  wire logic        rx_line_bit_valid,
  input  wire logic        one_second_flag,
  input  wire logic        five_second_flag,
  input  wire logic        facility_data_link_bit,
  input  wire logic        facility_data_link_valid,
  input  wire logic [3:0]  signaling_raw,
  input  wire logic [3:0]  signaling_debounced,
  output logic             signaling_debounce_enable
);
  tios_byte_t count_in [8];
  tios_byte_t count_q  [8];
  tios_byte_t wrap_ev;
  tios_byte_t ev3;
  tios_byte_t wrap_irq_q;
  tios_byte_t wrap_irq_d;
  tios_byte_t event_irq_q;
  tios_byte_t event_irq_d;
  tios_byte_t wrap_latch_q;
  tios_byte_t wrap_latch_d;
  tios_byte_t wrap_mask_q;
  tios_byte_t event_mask_q;
  tios_byte_t control_q;
  tios_byte_t rd_val;
  tios_byte_t clr_wrap;
  tios_byte_t clr_event;
  tios_byte_t clr_latch;
  tios_sel_e  sel;
  tios_sel_e  sel_q;
  logic [31:0] prdata_q;
  logic        pready_q;
  logic        pslverr_q;
  logic        setup;
  logic        access;
  logic        rd_done;
  logic        one_prev_q;
  logic        five_prev_q;
  logic [3:0]  sig_prev_q;
  logic [3:0]  sig_sel;
  logic        sig_valid_q;
  logic        sig_ev;
  logic        loop_ev;
  logic        bom_ev;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // Counter wrap detection, one per counter
  assign count_in[7] = frame_bit_err_count;
  assign count_in[6] = crc_err_count;
  assign count_in[5] = out_of_frame_count;
  assign count_in[4] = align_change_count;
  assign count_in[3] = line_violation_count;
  assign count_in[2] = test_pattern_err_count;
  assign count_in[1] = test_pattern_mf_count;
  assign count_in[0] = multiframe_sync_loss_count;

  genvar g;
  generate
    for (g = 0; g < 8; g++)
    begin : g_wrap
      always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
          count_q[g] <= 8'h00;
        else
          count_q[g] <= count_in[g];
      // Reset value zero so no false wrap right after reset
      assign wrap_ev[g] = (count_q[g] == `TIOS_WRAP_FROM) && (count_in[g] == `TIOS_WRAP_TO);
    end
  endgenerate

  // Edge and change detection for word three sources
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      one_prev_q  <= 1'b0;
      five_prev_q <= 1'b0;
    end
    else
    begin
      one_prev_q  <= one_second_flag;
      five_prev_q <= five_second_flag;
    end

  assign sig_sel = control_q[`TIOS_CTL_DEBOUNCE] ? signaling_debounced : signaling_raw;

  // First sample after reset only primes the compare register
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      sig_prev_q  <= 4'h0;
      sig_valid_q <= 1'b0;
    end
    else
    begin
      sig_prev_q  <= sig_sel;
      sig_valid_q <= 1'b1;
    end

  assign sig_ev = sig_valid_q && (sig_sel != sig_prev_q);

  tios_loop_detect #(
    .LOOP_CYCLES (LOOP_CYCLES)
  ) u_loop (
    .pclk         (pclk),
    .presetn      (presetn),
    .rx_bit       (rx_line_bit),
    .rx_bit_valid (rx_line_bit_valid),
    .loop_ev      (loop_ev)
  );

  tios_bom_detect u_bom (
    .pclk      (pclk),
    .presetn   (presetn),
    .fdl_bit   (facility_data_link_bit),
    .fdl_valid (facility_data_link_valid),
    .bom_ev    (bom_ev)
  );

  always_comb
  begin
    ev3                        = 8'h00;
    ev3[`TIOS_W3_FDL_CTRL]     = facility_link_ctrl_event;
    ev3[`TIOS_W3_SIG_CTRL]     = signaling_link_ctrl_event;
    ev3[`TIOS_W3_LOOP]         = loop_ev;
    ev3[`TIOS_W3_ONE_SEC]      = one_second_flag && !one_prev_q;
    ev3[`TIOS_W3_FIVE_SEC]     = five_second_flag && !five_prev_q;
    ev3[`TIOS_W3_BIT_MSG]      = bom_ev;
    ev3[`TIOS_W3_SIG_CHANGE]   = sig_ev;
  end

  // APB decode; byte address is four times the register index
  assign setup   = psel && !penable;
  assign access  = psel && penable && pready_q;
  assign rd_done = access && !pwrite;

  always_comb
  begin
    sel = TIOS_SEL_NONE;
    if (paddr[1:0] == 2'b00)
    begin
      case (paddr[7:2])
        6'(`TIOS_IDX_WRAP_IRQ):   sel = TIOS_SEL_WRAP_IRQ;
        6'(`TIOS_IDX_EVENT_IRQ):  sel = TIOS_SEL_EVENT_IRQ;
        6'(`TIOS_IDX_WRAP_LATCH): sel = TIOS_SEL_WRAP_LATCH;
        6'(`TIOS_IDX_WRAP_MASK):  sel = TIOS_SEL_WRAP_MASK;
        6'(`TIOS_IDX_EVENT_MASK): sel = TIOS_SEL_EVENT_MASK;
        6'(`TIOS_IDX_CONTROL):    sel = TIOS_SEL_CONTROL;
        default:                  sel = TIOS_SEL_NONE;
      endcase
    end
  end

  always_comb
  begin
    case (sel)
      TIOS_SEL_WRAP_IRQ:   rd_val = wrap_irq_q;
      TIOS_SEL_EVENT_IRQ:  rd_val = event_irq_q;
      TIOS_SEL_WRAP_LATCH: rd_val = wrap_latch_q;
      TIOS_SEL_WRAP_MASK:  rd_val = wrap_mask_q;
      TIOS_SEL_EVENT_MASK: rd_val = event_mask_q;
      TIOS_SEL_CONTROL:    rd_val = control_q;
      default:             rd_val = 8'h00;
    endcase
  end

  // One wait-free access phase: ready is high in the first access cycle
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      sel_q     <= TIOS_SEL_NONE;
    end
    else
    begin
      pready_q  <= setup;
      pslverr_q <= setup && (sel == TIOS_SEL_NONE);
      if (setup)
        sel_q <= sel;
    end

  // Data is captured at setup; the same snapshot drives the clear
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      prdata_q <= 32'h0000_0000;
    else if (setup && !pwrite)
      prdata_q <= {24'h000000, rd_val};

  assign clr_wrap  = (rd_done && sel_q == TIOS_SEL_WRAP_IRQ)   ? prdata_q[7:0] : 8'h00;
  assign clr_event = (rd_done && sel_q == TIOS_SEL_EVENT_IRQ)  ? prdata_q[7:0] : 8'h00;
  assign clr_latch = (rd_done && sel_q == TIOS_SEL_WRAP_LATCH) ? prdata_q[7:0] : 8'h00;

  // Set beats clear so an event during the read is kept
  assign wrap_irq_d   = (wrap_irq_q & ~clr_wrap)
                      | (wrap_ev & wrap_mask_q);
  assign event_irq_d  = ((event_irq_q & ~clr_event) | (ev3 & event_mask_q)) & `TIOS_W3_USED_MASK;
  assign wrap_latch_d = (wrap_latch_q & ~clr_latch) | wrap_ev;

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      wrap_irq_q   <= `TIOS_RST_STATUS;
      event_irq_q  <= `TIOS_RST_STATUS;
      wrap_latch_q <= `TIOS_RST_STATUS;
    end
    else
    begin
      wrap_irq_q   <= wrap_irq_d;
      event_irq_q  <= event_irq_d;
      wrap_latch_q <= wrap_latch_d;
    end

  // Writes to status words are ignored without error
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      wrap_mask_q  <= `TIOS_RST_MASK;
      event_mask_q <= `TIOS_RST_MASK;
      control_q    <= `TIOS_RST_CONTROL;
    end
    else if (access && pwrite)
    begin
      if (sel_q == TIOS_SEL_WRAP_MASK)
        wrap_mask_q <= pwdata[7:0];
      if (sel_q == TIOS_SEL_EVENT_MASK)
        event_mask_q <= pwdata[7:0] & `TIOS_W3_USED_MASK;
      if (sel_q == TIOS_SEL_CONTROL)
        control_q <= {7'h00, pwdata[`TIOS_CTL_DEBOUNCE]};
    end

  assign prdata                    = prdata_q;
  assign pready                    = pready_q;
  assign pslverr                   = pslverr_q;
  assign signaling_debounce_enable = control_q[`TIOS_CTL_DEBOUNCE];

  property p_frame_wrap;
    wrap_ev[7] && wrap_mask_q[7] |=> wrap_irq_q[7];
  endproperty
  a_frame_wrap: assert property (p_frame_wrap) else $error("frame wrap bit not set");

  property p_crc_wrap;
    (count_in[6] == 8'h00) && $past(count_in[6]) == 8'hFF && wrap_mask_q[6] |=> wrap_irq_q[6];
  endproperty
  a_crc_wrap: assert property (p_crc_wrap) else $error("crc wrap bit not set");

  property p_masked_quiet;
    !wrap_mask_q[3] && !wrap_irq_q[3] |=> !wrap_irq_q[3];
  endproperty
  a_masked_quiet: assert property (p_masked_quiet) else $error("masked event set a status bit");

  property p_read_clears;
    rd_done && sel_q == TIOS_SEL_WRAP_IRQ && prdata_q[0] && !(wrap_ev[0] && wrap_mask_q[0]) |=> !wrap_irq_q[0];
  endproperty
  a_read_clears: assert property (p_read_clears) else $error("read did not clear bit");

  property p_unread_kept;
    rd_done && sel_q == TIOS_SEL_EVENT_IRQ && !prdata_q[2] && event_irq_q[2] |=> event_irq_q[2];
  endproperty
  a_unread_kept: assert property (p_unread_kept) else $error("bit cleared that was not returned");

  property p_latch_wrap;
    wrap_ev[5] |=> wrap_latch_q[5] ##1 (wrap_latch_q[5] || $past(rd_done));
  endproperty
  a_latch_wrap: assert property (p_latch_wrap) else $error("latch not set on wrap");

  property p_one_second;
    $rose(one_second_flag) && event_mask_q[`TIOS_W3_ONE_SEC] |=> event_irq_q[`TIOS_W3_ONE_SEC];
  endproperty
  a_one_second: assert property (p_one_second) else $error("one second tick lost");

  property p_five_second;
    $rose(five_second_flag) && event_mask_q[`TIOS_W3_FIVE_SEC] |=> event_irq_q[`TIOS_W3_FIVE_SEC];
  endproperty
  a_five_second: assert property (p_five_second) else $error("five second tick lost");

  property p_event_masked;
    !event_mask_q[`TIOS_W3_FDL_CTRL] && !event_irq_q[`TIOS_W3_FDL_CTRL] |=> !event_irq_q[`TIOS_W3_FDL_CTRL];
  endproperty
  a_event_masked: assert property (p_event_masked) else $error("masked link event set a status bit");

  property p_sig_change;
    sig_valid_q && sig_sel != $past(sig_sel) && event_mask_q[0] |=> event_irq_q[0];
  endproperty
  a_sig_change: assert property (p_sig_change) else $error("signaling change lost");

  property p_setup_ready;
    setup |=> pready_q ##1 !pready_q;
  endproperty
  a_setup_ready: assert property (p_setup_ready) else $error("ready not one cycle after setup");
endmodule : tios_status

// ### test/tios_host.sv
// Host processor model issuing APB transfers to the status block
`timescale 1ns/10ps
module tios_host (
  input  wire logic        pclk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  initial
  begin
    psel <= 1'b0;
    penable <= 1'b0;
    pwrite <= 1'b0;
    paddr <= 8'h00;
    pwdata <= 32'h0000_0000;
  end

  // Called just after a rising edge; holds the request until pready, the bench timeout ends a hang
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Idle edge so the next setup never lands in the release step
    @(posedge pclk);
  endtask : xfer
endmodule : tios_host

// ### test/test_tios_status.sv
// Self-checking bench for the interrupt and overflow status block
`timescale 1ns/10ps
`include "tios_defines.svh"
module test_tios_status;
  import tios_pkg::*;
  localparam int LOOP_N = 50;
  localparam logic [7:0] A_WRAP = 8'(`TIOS_IDX_WRAP_IRQ * 4);
  localparam logic [7:0] A_EVT  = 8'(`TIOS_IDX_EVENT_IRQ * 4);
  localparam logic [7:0] A_LAT  = 8'(`TIOS_IDX_WRAP_LATCH * 4);
  localparam logic [7:0] A_WMSK = 8'(`TIOS_IDX_WRAP_MASK * 4);
  localparam logic [7:0] A_EMSK = 8'(`TIOS_IDX_EVENT_MASK * 4);
  localparam logic [7:0] A_CTL  = 8'(`TIOS_IDX_CONTROL * 4);
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic [7:0]  cnt [8];
  logic        fac_ev = 1'b0, sig_ev = 1'b0, rx_bit = 1'b0, rx_vld = 1'b0;
  logic        one_s = 1'b0, five_s = 1'b0, fdl_bit = 1'b0, fdl_vld = 1'b0;
  logic [3:0]  sig_raw = 4'h0, sig_deb = 4'h0;
  logic        deb_en;
  int          error_cnt = 0, n_checks = 0, cyc = 0;

  always #12.5 pclk = ~pclk;
  initial for (int i = 0; i < 8; i++) cnt[i] = 8'h00;

  tios_status #(.LOOP_CYCLES(LOOP_N)) tios_status_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .frame_bit_err_count(cnt[0]), .crc_err_count(cnt[1]), .out_of_frame_count(cnt[2]),
    .align_change_count(cnt[3]), .line_violation_count(cnt[4]), .test_pattern_err_count(cnt[5]),
    .test_pattern_mf_count(cnt[6]), .multiframe_sync_loss_count(cnt[7]),
    .facility_link_ctrl_event(fac_ev), .signaling_link_ctrl_event(sig_ev),
    .rx_line_bit(rx_bit), .rx_line_bit_valid(rx_vld), .one_second_flag(one_s),
    .five_second_flag(five_s), .facility_data_link_bit(fdl_bit), .facility_data_link_valid(fdl_vld),
    .signaling_raw(sig_raw), .signaling_debounced(sig_deb), .signaling_debounce_enable(deb_en));

  tios_host tios_host_i (
    .pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  task automatic results();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : results

  // Hang guard, well above the fewer than one thousand cycles the run needs
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      error_cnt++;
      results();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    n_checks++;
    if (got !== exp)
    begin
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, msg, got, exp);
      error_cnt++;
    end
  endtask : chk

  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string msg);
    logic [31:0] d;
    logic        e;
    tios_host_i.xfer(1'b0, a, 32'h0, d, e);
    chk({31'h0, e}, 32'h0, {msg, " error flag"});
    chk(d, {24'h0, exp}, msg);
  endtask : rd

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    logic [31:0] d;
    logic        e;
    tios_host_i.xfer(1'b1, a, {24'h0, v}, d, e);
  endtask : wr

  // Counters selected by sel go FF then 00 on consecutive edges
  task automatic wrap(input logic [7:0] sel);
    for (int i = 0; i < 8; i++) if (sel[7-i]) cnt[i] <= 8'hFF;
    @(posedge pclk);
    for (int i = 0; i < 8; i++) if (sel[7-i]) cnt[i] <= 8'h00;
    @(posedge pclk);
    @(posedge pclk);
  endtask : wrap

  task automatic t_reset();
    rd(A_WRAP, 8'h00, "wrap word reset");
    rd(A_EVT, 8'h00, "event word reset");
    rd(A_LAT, 8'h00, "latch reset");
    rd(A_WMSK, 8'h00, "wrap mask reset");
    rd(A_EMSK, 8'h00, "event mask reset");
    rd(A_CTL, 8'h00, "control reset");
  endtask : t_reset

  task automatic t_wrap();
    wr(A_WMSK, 8'h0F);
    wrap(8'hFF);
    rd(A_WRAP, 8'h0F, "partial mask");
    rd(A_LAT, 8'hFF, "latches ignore mask");
    rd(A_LAT, 8'h00, "latches clear on read");
    wr(A_WMSK, 8'hFF);
    for (int b = 7; b >= 0; b--)
    begin
      wrap(8'h01 << b);
      rd(A_WRAP, 8'h01 << b, "wrap bit");
      rd(A_WRAP, 8'h00, "wrap clear on read");
      rd(A_LAT, 8'h01 << b, "latch bit");
    end
    cnt[2] <= 8'hFE;
    @(posedge pclk);
    cnt[2] <= 8'hFF;
    @(posedge pclk);
    rd(A_WRAP, 8'h00, "count up without wrap");
  endtask : t_wrap

  task automatic t_events();
    rd(A_EVT, 8'h00, "masked levels");
    fac_ev <= 1'b1;
    sig_ev <= 1'b1;
    @(posedge pclk);
    fac_ev <= 1'b0;
    sig_ev <= 1'b0;
    @(posedge pclk);
    rd(A_EVT, 8'h00, "masked events");
    wr(A_EMSK, 8'hFF);
    rd(A_EMSK, 8'h7F, "event mask top bit unused");
    fac_ev <= 1'b1;
    sig_ev <= 1'b1;
    one_s <= 1'b1;
    five_s <= 1'b1;
    sig_raw <= 4'h5;
    @(posedge pclk);
    fac_ev <= 1'b0;
    sig_ev <= 1'b0;
    @(posedge pclk);
    rd(A_EVT, 8'h6D, "event word");
    rd(A_EVT, 8'h00, "event word clear");
    fac_ev <= 1'b1;
    @(posedge pclk);
    fac_ev <= 1'b0;
    fork
      rd(A_EVT, 8'h40, "read during event");
      begin
        @(posedge pclk);
        fac_ev <= 1'b1;
        @(posedge pclk);
        fac_ev <= 1'b0;
      end
    join
    rd(A_EVT, 8'h40, "event kept over clear");
    one_s <= 1'b0;
    five_s <= 1'b0;
    @(posedge pclk);
    rd(A_EVT, 8'h00, "falling flags");
    wr(A_CTL, 8'h01);
    chk({31'h0, deb_en}, 32'h1, "debounce enable pin");
    rd(A_EVT, 8'h01, "debounce switch change");
    sig_raw <= 4'hA;
    @(posedge pclk);
    rd(A_EVT, 8'h00, "raw ignored when debounced");
    sig_deb <= 4'h3;
    @(posedge pclk);
    rd(A_EVT, 8'h01, "debounced change");
  endtask : t_events

  task automatic t_loop(input int period);
    for (int i = 0; i < 2 * LOOP_N; i++)
    begin
      rx_vld <= 1'b1;
      rx_bit <= (i % period == period - 1);
      @(posedge pclk);
    end
    rx_vld <= 1'b0;
    rx_bit <= 1'b0;
    @(posedge pclk);
    rd(A_EVT, 8'h10, "loop code");
  endtask : t_loop

  task automatic t_msg(input logic [15:0] code, input int reps, input logic [7:0] exp);
    for (int r = 0; r < reps; r++)
      for (int i = 15; i >= 0; i--)
      begin
        fdl_vld <= 1'b1;
        fdl_bit <= code[i];
        @(posedge pclk);
      end
    fdl_vld <= 1'b0;
    @(posedge pclk);
    rd(A_EVT, exp, "bit message");
  endtask : t_msg

  task automatic t_unmapped();
    logic [31:0] d;
    logic        e;
    tios_host_i.xfer(1'b0, 8'h90, 32'h0, d, e);
    chk({31'h0, e}, 32'h1, "unmapped error");
    chk(d, 32'h0, "unmapped data");
    tios_host_i.xfer(1'b0, 8'h75, 32'h0, d, e);
    chk({31'h0, e}, 32'h1, "misaligned error");
  endtask : t_unmapped

  initial
  begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_wrap();
    t_events();
    t_loop(5);
    t_loop(3);
    t_msg(16'hFF54, 7, 8'h00);
    t_msg(16'hFF54, 3, 8'h02);
    t_msg(16'hFF54, 10, 8'h00);
    t_msg(16'hFF28, 10, 8'h02);
    t_unmapped();
    results();
  end
endmodule : test_tios_status
